// ==== vectored_interrupt_priority_unit.sv ====
// vectored interrupt unit: flags, enables, priorities, cpu level and vector fetch
`timescale 1ns/100ps
module vectored_interrupt_priority_unit
    import irq_unit_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // register port
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [DATA_W-1:0]      reg_rdata,
    // peripheral events, one-cycle pulses on this clock
    input  wire logic [NUM_VECTORS-1:0] src_event,
    // processor core
    input  wire logic                   cpu_take,
    input  wire logic                   core_load,
    input  wire logic [3:0]             core_level,
    output logic                        req_valid,
    output logic      [VEC_W-1:0]       req_vector,
    output logic      [2:0]             req_prio,
    output logic      [FETCH_W-1:0]     fetch_addr,
    output logic      [3:0]             cpu_level,
    // summary interrupt
    output logic                        irq
);
    irq_core_if cif ();

    logic [NUM_VECTORS-1:0] flag;
    logic [NUM_VECTORS-1:0] next_flag;
    logic [NUM_VECTORS-1:0] enable;
    logic [2:0]             prio_tbl [NUM_VECTORS];
    logic                   nest_dis;
    logic                   alt_sel;
    logic                   psv;
    logic [NUM_EVT-1:0]     evt_status;
    logic [NUM_EVT-1:0]     evt_enable;
    logic [NUM_EVT-1:0]     evt_hit;
    logic [DATA_W-1:0]      next_rdata;
    logic                   taken;

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        return reg_wr && reg_addr == ofs;
    endfunction

    assign taken = cpu_take && req_valid;

    // flags: software may set or clear, a same-cycle event still wins
    always_comb begin
        next_flag = flag;
        for (int g = 0; g < FLAG_GROUPS; g++) begin
            if (hit(ADDR_W'(OFS_FLAG_BASE + g))) begin
                next_flag[g*DATA_W +: DATA_W] = reg_wdata;
            end
        end
        next_flag = next_flag | src_event;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable <= '0;
        end else begin
            for (int g = 0; g < FLAG_GROUPS; g++) begin
                if (hit(ADDR_W'(OFS_ENABLE_BASE + g))) begin
                    enable[g*DATA_W +: DATA_W] <= reg_wdata;
                end
            end
        end
    end

    // four 3-bit fields per priority group; vector 4g+k lives in field k
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_VECTORS; i++) begin
                prio_tbl[i] <= RST_PRIO;
            end
        end else begin
            for (int g = 0; g < PRIO_GROUPS; g++) begin
                if (hit(ADDR_W'(OFS_PRIO_BASE + g))) begin
                    for (int k = 0; k < FIELDS_PER_GROUP; k++) begin
                        prio_tbl[g*FIELDS_PER_GROUP + k] <= reg_wdata[4*k +: 3];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nest_dis <= 1'b0;
            alt_sel  <= 1'b0;
            psv      <= 1'b0;
        end else begin
            if (hit(OFS_INTCON_ONE)) begin
                nest_dis <= reg_wdata[POS_NEST_DIS];
            end
            if (hit(OFS_INTCON_TWO)) begin
                alt_sel <= reg_wdata[POS_ALT_SEL];
            end
            if (hit(OFS_CORE_CTRL)) begin
                psv <= reg_wdata[POS_PSV];
            end
        end
    end

    // connections to the level holder and the arbiter
    // decodes spelled out: a continuous assign would not wake on signals read inside hit()
    assign cif.field_wr    = reg_wr && reg_addr == OFS_STATUS_WORD;
    assign cif.field_wdata = reg_wdata[POS_PRIO_FIELD +: 3];
    // writing 1 to the high bit is ignored; only a 0 acts
    assign cif.high_clr    = reg_wr && reg_addr == OFS_CORE_CTRL && !reg_wdata[POS_HIGH_BIT];
    assign cif.nest_dis    = nest_dis;
    // the core's own load beats a take landing in the same cycle
    assign cif.load        = core_load || taken;
    assign cif.load_value  = core_load ? core_level : {1'b0, req_prio};
    assign cif.alt_sel     = alt_sel;
    assign cif.take        = taken;
    assign cif.pending     = flag & enable;
    assign cif.prio        = prio_tbl;

    cpu_level_holder u_level (
        .clk   (clk),
        .reset (reset),
        .lv    (cif.level_side)
    );

    request_arbiter u_arb (
        .clk   (clk),
        .reset (reset),
        .ar    (cif.arb_side)
    );

    assign req_valid  = cif.req_valid;
    assign req_vector = cif.req_vector;
    assign req_prio   = cif.req_prio;
    assign fetch_addr = cif.req_fetch;
    assign cpu_level  = cif.level;

    // summary events: request taken, locked field write refused
    assign evt_hit[EVT_TAKEN]   = taken;
    assign evt_hit[EVT_REFUSED] = cif.field_wr && nest_dis;

    always_ff @(posedge clk) begin
        if (reset) begin
            evt_status <= '0;
        end else if (hit(OFS_EVT_CLEAR)) begin
            evt_status <= (evt_status & ~reg_wdata[NUM_EVT-1:0]) | evt_hit;
        end else begin
            evt_status <= evt_status | evt_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            evt_enable <= '0;
        end else if (hit(OFS_EVT_ENABLE)) begin
            evt_enable <= reg_wdata[NUM_EVT-1:0];
        end
    end

    assign irq = |(evt_status & evt_enable);

    // read mux; unmapped and write-only offsets read zero
    always_comb begin
        next_rdata = RST_WORD;
        for (int g = 0; g < FLAG_GROUPS; g++) begin
            if (reg_addr == ADDR_W'(OFS_FLAG_BASE + g)) begin
                next_rdata = flag[g*DATA_W +: DATA_W];
            end
            if (reg_addr == ADDR_W'(OFS_ENABLE_BASE + g)) begin
                next_rdata = enable[g*DATA_W +: DATA_W];
            end
        end
        for (int g = 0; g < PRIO_GROUPS; g++) begin
            if (reg_addr == ADDR_W'(OFS_PRIO_BASE + g)) begin
                for (int k = 0; k < FIELDS_PER_GROUP; k++) begin
                    next_rdata[4*k +: 3] = prio_tbl[g*FIELDS_PER_GROUP + k];
                end
            end
        end
        case (reg_addr)
            OFS_STATUS_WORD: next_rdata[POS_PRIO_FIELD +: 3] = cif.level[2:0];
            OFS_CORE_CTRL: begin
                next_rdata[POS_HIGH_BIT] = cif.level[3];
                next_rdata[POS_PSV]      = psv;
            end
            OFS_INTCON_ONE: next_rdata[POS_NEST_DIS] = nest_dis;
            OFS_INTCON_TWO: next_rdata[POS_ALT_SEL]  = alt_sel;
            OFS_EVT_STATUS: next_rdata[NUM_EVT-1:0]  = evt_status;
            OFS_EVT_ENABLE: next_rdata[NUM_EVT-1:0]  = evt_enable;
            OFS_REQ_VIEW: begin
                next_rdata[POS_REQ_VALID] = req_valid;
                next_rdata[VEC_W-1:0]     = req_vector;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= RST_WORD;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    property p_ext0_entry;
        @(posedge clk) disable iff (reset)
        req_valid && req_vector == 7'h00 |->
            fetch_addr == ($past(alt_sel) ? 24'h000114 : 24'h000014);
    endproperty
    a_ext0_entry: assert property (p_ext0_entry) else $error("vector 0 fetch address wrong");

    property p_capture_one;
        @(posedge clk) disable iff (reset)
        req_valid && req_vector == 7'h01 |->
            req_prio == $past(prio_tbl[1]) && fetch_addr[7:0] == 8'h16;
    endproperty
    a_capture_one: assert property (p_capture_one) else $error("vector 1 priority or entry wrong");

    property p_converter_flag;
        @(posedge clk) disable iff (reset)
        src_event[13] |=> flag[13];
    endproperty
    a_converter_flag: assert property (p_converter_flag) else $error("converter event lost");

    property p_capture_nine;
        @(posedge clk) disable iff (reset)
        req_valid && req_vector == 7'h5d |->
            fetch_addr == ($past(alt_sel) ? 24'h0001ce : 24'h0000ce);
    endproperty
    a_capture_nine: assert property (p_capture_nine) else $error("vector 93 fetch address wrong");

    property p_pmp_entry;
        @(posedge clk) disable iff (reset)
        req_valid && req_vector == 7'h2d && !$past(alt_sel) |-> fetch_addr == 24'h00006e;
    endproperty
    a_pmp_entry: assert property (p_pmp_entry) else $error("vector 45 fetch address wrong");

    property p_level_seven_blocks;
        @(posedge clk) disable iff (reset)
        $past(cpu_level) == 4'h7 |-> !req_valid;
    endproperty
    a_level_seven_blocks: assert property (p_level_seven_blocks) else $error("request taken at level 7");

    // the index is today's vector; only the flag and enable words are taken from the last cycle
    property p_pending_needs_enable;
        @(posedge clk) disable iff (reset)
        req_valid |-> |($past(flag & enable) & (NUM_VECTORS'(1) << req_vector));
    endproperty
    a_pending_needs_enable: assert property (p_pending_needs_enable) else $error("request not pending");

    property p_take_raises_level;
        @(posedge clk) disable iff (reset)
        taken && !core_load |=> cpu_level == {1'b0, $past(req_prio)} && !req_valid;
    endproperty
    a_take_raises_level: assert property (p_take_raises_level) else $error("take did not raise level");

    property p_take_event;
        @(posedge clk) disable iff (reset)
        taken |=> evt_status[EVT_TAKEN];
    endproperty
    a_take_event: assert property (p_take_event) else $error("take not recorded");

    property p_refused_event;
        @(posedge clk) disable iff (reset)
        cif.field_wr && nest_dis && !cif.load |=> evt_status[EVT_REFUSED] && cpu_level[2:0] == $past(cpu_level[2:0]);
    endproperty
    a_refused_event: assert property (p_refused_event) else $error("locked write not refused");

    property p_high_clear;
        @(posedge clk) disable iff (reset)
        cif.high_clr && !cif.load |=> !cpu_level[3];
    endproperty
    a_high_clear: assert property (p_high_clear) else $error("high bit not cleared");

    property p_high_level_blocks;
        @(posedge clk) disable iff (reset)
        $past(cpu_level[3]) |-> !req_valid;
    endproperty
    a_high_level_blocks: assert property (p_high_level_blocks) else $error("request above level 7");

    property p_status_read;
        @(posedge clk) disable iff (reset)
        reg_rd && reg_addr == OFS_STATUS_WORD |=> reg_rdata[POS_PRIO_FIELD +: 3] == $past(cpu_level[2:0]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status field read wrong");
endmodule

// ==== irq_unit_pkg.sv ====
// constants, register map and helpers shared by the vectored interrupt unit
package irq_unit_pkg;
    localparam int NUM_VECTORS = 96;
    localparam int FLAG_GROUPS = 6;
    localparam int PRIO_GROUPS = 24;
    localparam int FIELDS_PER_GROUP = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int VEC_W = 7;
    localparam int FETCH_W = 24;
    localparam int NUM_EVT = 2;

    // register offsets (word index on the register port)
    localparam logic [7:0] OFS_FLAG_BASE   = 8'h00;
    localparam logic [7:0] OFS_ENABLE_BASE = 8'h08;
    localparam logic [7:0] OFS_PRIO_BASE   = 8'h10;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h28;
    localparam logic [7:0] OFS_CORE_CTRL   = 8'h29;
    localparam logic [7:0] OFS_INTCON_ONE  = 8'h2a;
    localparam logic [7:0] OFS_INTCON_TWO  = 8'h2b;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h2c;
    localparam logic [7:0] OFS_EVT_ENABLE  = 8'h2d;
    localparam logic [7:0] OFS_EVT_CLEAR   = 8'h2e;
    localparam logic [7:0] OFS_REQ_VIEW    = 8'h2f;

    // field positions
    localparam int POS_PRIO_FIELD = 5;
    localparam int POS_HIGH_BIT   = 3;
    localparam int POS_PSV        = 2;
    localparam int POS_NEST_DIS   = 15;
    localparam int POS_ALT_SEL    = 0;
    localparam int POS_REQ_VALID  = 15;
    localparam int EVT_TAKEN      = 0;
    localparam int EVT_REFUSED    = 1;

    // reset values
    localparam logic [2:0]  RST_FIELD = 3'h0;
    localparam logic [2:0]  RST_PRIO  = 3'h4;
    localparam logic [15:0] RST_WORD  = 16'h0000;

    // vector table bases
    localparam logic [23:0] PRIMARY_VECTOR_TABLE   = 24'h000014;
    localparam logic [23:0] ALTERNATE_VECTOR_TABLE = 24'h000114;

    // each vector-table entry is two address units wide
    function automatic logic [23:0] vector_entry(input logic [6:0] vec, input logic alt);
        logic [23:0] base;
        base = alt ? ALTERNATE_VECTOR_TABLE : PRIMARY_VECTOR_TABLE;
        return base + {16'h0000, vec, 1'b0};
    endfunction
endpackage

// ==== irq_core_if.sv ====
// signals between the register front, the level holder and the arbiter
`timescale 1ns/100ps
interface irq_core_if;
    import irq_unit_pkg::*;
    logic                   field_wr;
    logic [2:0]             field_wdata;
    logic                   high_clr;
    logic                   load;
    logic [3:0]             load_value;
    logic                   nest_dis;
    logic [3:0]             level;
    logic                   alt_sel;
    logic                   take;
    logic [NUM_VECTORS-1:0] pending;
    logic [2:0]             prio [NUM_VECTORS];
    logic                   req_valid;
    logic [VEC_W-1:0]       req_vector;
    logic [2:0]             req_prio;
    logic [FETCH_W-1:0]     req_fetch;

    modport level_side (input field_wr, field_wdata, high_clr, load, load_value, nest_dis,
                        output level);
    modport arb_side (input pending, prio, level, alt_sel, take,
                      output req_valid, req_vector, req_prio, req_fetch);
    modport ctrl (output field_wr, field_wdata, high_clr, load, load_value, nest_dis,
                  alt_sel, take, pending, prio,
                  input level, req_valid, req_vector, req_prio, req_fetch);
endinterface

// ==== cpu_level_holder.sv ====
// cpu priority level: 3-bit status field plus the high bit of the core control word
`timescale 1ns/100ps
module cpu_level_holder
    import irq_unit_pkg::*;
(
    // clock and reset
    input wire logic   clk,
    input wire logic   reset,
    // level controls
    irq_core_if.level_side lv
);
    logic [2:0] field;
    logic       high;

    always_ff @(posedge clk) begin
        if (reset) begin
            field <= RST_FIELD;
            high  <= 1'b0;
        end else if (lv.load) begin
            // hardware load is the only way the high bit can rise
            field <= lv.load_value[2:0];
            high  <= lv.load_value[3];
        end else begin
            if (lv.field_wr && !lv.nest_dis) begin
                field <= lv.field_wdata;
            end
            if (lv.high_clr) begin
                high <= 1'b0;
            end
        end
    end

    // high bit selects levels 8..15 over the same field codes
    assign lv.level = {high, field};

    property p_high_only_by_load;
        @(posedge clk) disable iff (reset)
        $rose(high) |-> $past(lv.load) && $past(lv.load_value[3]);
    endproperty
    a_high_only_by_load: assert property (p_high_only_by_load) else $error("high bit set without load");

    property p_nest_locks_field;
        @(posedge clk) disable iff (reset)
        lv.field_wr && lv.nest_dis && !lv.load |=> field == $past(field);
    endproperty
    a_nest_locks_field: assert property (p_nest_locks_field) else $error("field written while locked");

    property p_level_joins;
        @(posedge clk) disable iff (reset)
        lv.load |=> lv.level == $past(lv.load_value);
    endproperty
    a_level_joins: assert property (p_level_joins) else $error("loaded level not held");
endmodule

// ==== request_arbiter.sv ====
// picks the highest pending source above the cpu level and registers its vector
`timescale 1ns/100ps
module request_arbiter
    import irq_unit_pkg::*;
(
    // clock and reset
    input wire logic  clk,
    input wire logic  reset,
    // arbitration
    irq_core_if.arb_side ar
);
    logic             next_valid;
    logic [VEC_W-1:0] next_vector;
    logic [2:0]       next_prio;
    logic [3:0]       bar;

    // strict compare keeps the lowest vector on a priority tie
    always_comb begin
        next_valid  = 1'b0;
        next_vector = '0;
        next_prio   = 3'h0;
        bar         = ar.level;
        for (int i = 0; i < NUM_VECTORS; i++) begin
            if (ar.pending[i] && {1'b0, ar.prio[i]} > bar) begin
                bar         = {1'b0, ar.prio[i]};
                next_valid  = 1'b1;
                next_vector = VEC_W'(i);
                next_prio   = ar.prio[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ar.req_valid  <= 1'b0;
            ar.req_vector <= '0;
            ar.req_prio   <= 3'h0;
            ar.req_fetch  <= PRIMARY_VECTOR_TABLE;
        end else begin
            // a taken request drops for one cycle so the new level is seen first
            ar.req_valid  <= next_valid && !ar.take;
            ar.req_vector <= next_vector;
            ar.req_prio   <= next_prio;
            ar.req_fetch  <= vector_entry(next_vector, ar.alt_sel);
        end
    end

    property p_above_level;
        @(posedge clk) disable iff (reset)
        ar.req_valid |-> {1'b0, ar.req_prio} > $past(ar.level);
    endproperty
    a_above_level: assert property (p_above_level) else $error("request not above cpu level");
endmodule

// ==== core_model.sv ====
// processor core stand-in: takes a pending request promptly or after a delay
`timescale 1ns/100ps
module core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // take control
    input  wire logic       arm,
    input  wire logic [1:0] delay,
    // request side
    input  wire logic       req_valid,
    output logic            cpu_take
);
    logic [1:0] wait_cnt;

    // one-cycle take, raised only while the request is seen valid
    always @(posedge clk) begin
        if (reset || !arm || !req_valid || cpu_take) begin
            cpu_take <= 1'b0;
            wait_cnt <= delay;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else begin
            cpu_take <= 1'b1;
        end
    end
endmodule

// ==== vectored_interrupt_priority_unit_tb_top.sv ====
// self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module vectored_interrupt_priority_unit_tb_top;
    import irq_unit_pkg::*;
    logic                   clk;
    logic                   reset;
    logic [ADDR_W-1:0]      reg_addr;
    logic [DATA_W-1:0]      reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [DATA_W-1:0]      reg_rdata;
    logic [NUM_VECTORS-1:0] src_event;
    logic                   cpu_take;
    logic                   core_load;
    logic [3:0]             core_level;
    logic                   req_valid;
    logic [VEC_W-1:0]       req_vector;
    logic [2:0]             req_prio;
    logic [FETCH_W-1:0]     fetch_addr;
    logic [3:0]             cpu_level;
    logic                   irq;
    logic                   arm;
    logic [1:0]             delay;
    logic [15:0]            prio_sh [PRIO_GROUPS];
    logic [15:0]            en_sh [FLAG_GROUPS];
    logic [15:0]            d;
    logic [2:0]             p;
    logic [2:0]             lv;
    int                     v;
    int                     a;
    int                     error_cnt;
    int                     samples_checked;
    int                     cyc;
    int                     vt [5] = '{0, 1, 13, 45, 93};
    logic [23:0]            et [5] = '{24'h000014, 24'h000016, 24'h00002e, 24'h00006e, 24'h0000ce};

    vectored_interrupt_priority_unit dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_event(src_event), .cpu_take(cpu_take), .core_load(core_load), .core_level(core_level),
        .req_valid(req_valid), .req_vector(req_vector), .req_prio(req_prio), .fetch_addr(fetch_addr),
        .cpu_level(cpu_level), .irq(irq));
    core_model core_u (.clk(clk), .reset(reset), .arm(arm), .delay(delay), .req_valid(req_valid),
        .cpu_take(cpu_take));

    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang costs a mismatch rather than a stuck run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] ad, input logic [15:0] val);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= val;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic settle();
        @(posedge clk);
        @(negedge clk);
    endtask
    // request shows two edges after the pulse
    task automatic ev(input logic [NUM_VECTORS-1:0] m);
        @(posedge clk);
        src_event <= m;
        @(posedge clk);
        src_event <= '0;
        settle();
    endtask
    task automatic set_prio(input int n, input logic [2:0] pr);
        prio_sh[n/4][4*(n%4)+:3] = pr;
        wr(OFS_PRIO_BASE + 8'(n/4), prio_sh[n/4]);
    endtask
    task automatic en(input int n, input logic b);
        en_sh[n/16][n%16] = b;
        wr(OFS_ENABLE_BASE + 8'(n/16), en_sh[n/16]);
    endtask
    task automatic wait_level(input logic [3:0] l);
        for (int k = 0; k < 12 && cpu_level !== l; k++) @(negedge clk);
    endtask
    function automatic logic [NUM_VECTORS-1:0] bit_of(input int n);
        bit_of = '0;
        bit_of[n] = 1'b1;
    endfunction
    function automatic logic [23:0] entry(input int n, input int alt);
        return (alt == 1 ? 24'h000114 : 24'h000014) + 24'(2 * n);
    endfunction

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src_event = '0;
        core_load = 1'b0;
        core_level = 4'h0;
        arm = 1'b0;
        delay = 2'h0;
        foreach (prio_sh[i]) prio_sh[i] = 16'h4444;
        foreach (en_sh[i]) en_sh[i] = 16'h0000;
        void'($urandom(32'h09df));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_STATUS_WORD);
        `CHK("status", 16'h0000, d)
        rd(OFS_CORE_CTRL);
        `CHK("core ctrl", 16'h0000, d)
        rd(OFS_PRIO_BASE);
        `CHK("prio group", 16'h4444, d)
        rd(8'h30);
        `CHK("unmapped", 16'h0000, d)
        `CHK("fetch reset", 24'h000014, fetch_addr)
        $display("test reset done");
        for (a = 0; a < 2; a++) begin
            wr(OFS_INTCON_TWO, 16'(a));
            foreach (vt[i]) begin
                en(vt[i], 1'b1);
                ev(bit_of(vt[i]));
                `CHK("vector", 7'(vt[i]), req_vector)
                `CHK("entry", entry(0, a) + et[i] - 24'h000014, fetch_addr)
                rd(OFS_FLAG_BASE + 8'(vt[i] / 16));
                `CHK("flag", 16'h0001 << (vt[i] % 16), d)
                wr(OFS_FLAG_BASE + 8'(vt[i] / 16), 16'h0000);
                en(vt[i], 1'b0);
            end
        end
        wr(OFS_INTCON_TWO, 16'h0000);
        $display("test table done");
        set_prio(0, 3'h2);
        set_prio(1, 3'h6);
        set_prio(45, 3'h5);
        en(0, 1'b1);
        en(1, 1'b1);
        en(45, 1'b1);
        ev(bit_of(0) | bit_of(1) | bit_of(45));
        `CHK("top vector", 7'h01, req_vector)
        `CHK("top prio", 3'h6, req_prio)
        set_prio(1, 3'h1);
        settle();
        `CHK("next vector", 7'h2d, req_vector)
        set_prio(45, 3'h1);
        settle();
        `CHK("last vector", 7'h00, req_vector)
        set_prio(0, 3'h7);
        wr(OFS_STATUS_WORD, 16'h00e0);
        settle();
        `CHK("level 7", 4'h7, cpu_level)
        `CHK("blocked", 1'b0, req_valid)
        wr(OFS_STATUS_WORD, 16'h00c0);
        settle();
        `CHK("above 6", 1'b1, req_valid)
        set_prio(0, 3'h6);
        settle();
        `CHK("equal", 1'b0, req_valid)
        wr(OFS_FLAG_BASE, 16'h0000);
        wr(OFS_FLAG_BASE + 8'h02, 16'h0000);
        $display("test priority done");
        wr(OFS_CORE_CTRL, 16'h000c);
        rd(OFS_CORE_CTRL);
        `CHK("no set", 16'h0004, d)
        @(posedge clk);
        core_level <= 4'hb;
        core_load <= 1'b1;
        @(posedge clk);
        core_load <= 1'b0;
        @(negedge clk);
        `CHK("level 11", 4'hb, cpu_level)
        rd(OFS_CORE_CTRL);
        `CHK("high bit", 16'h000c, d)
        rd(OFS_STATUS_WORD);
        `CHK("field", 16'h0060, d)
        wr(OFS_CORE_CTRL, 16'h0000);
        settle();
        `CHK("cleared", 4'h3, cpu_level)
        $display("test high bit done");
        wr(OFS_EVT_ENABLE, 16'h0003);
        wr(OFS_INTCON_ONE, 16'h8000);
        wr(OFS_STATUS_WORD, 16'h00a0);
        rd(OFS_STATUS_WORD);
        `CHK("locked", 16'h0060, d)
        rd(OFS_EVT_STATUS);
        `CHK("refused evt", 16'h0002, d)
        `CHK("irq on", 1'b1, irq)
        wr(OFS_EVT_ENABLE, 16'h0000);
        settle();
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_EVT_CLEAR, 16'h0002);
        rd(OFS_EVT_STATUS);
        `CHK("evt clear", 16'h0000, d)
        wr(OFS_INTCON_ONE, 16'h0000);
        wr(OFS_STATUS_WORD, 16'h0000);
        rd(OFS_STATUS_WORD);
        `CHK("unlocked", 16'h0000, d)
        $display("test nesting done");
        wr(OFS_EVT_ENABLE, 16'h0001);
        for (int n = 0; n < 24; n++) begin
            v = int'($urandom % NUM_VECTORS);
            p = 3'(1 + $urandom % 7);
            lv = 3'($urandom % p);
            a = int'($urandom % 2);
            wr(OFS_STATUS_WORD, {8'h00, lv, 5'h00});
            wr(OFS_INTCON_TWO, 16'(a));
            set_prio(v, p);
            en(v, 1'b1);
            delay <= 2'($urandom % 4);
            ev(bit_of(v));
            `CHK("rand vector", 7'(v), req_vector)
            `CHK("rand entry", entry(v, a), fetch_addr)
            rd(OFS_REQ_VIEW);
            `CHK("req view", 16'h8000 | 16'(v), d)
            arm <= 1'b1;
            wait_level({1'b0, p});
            arm <= 1'b0;
            `CHK("rand level", {1'b0, p}, cpu_level)
            `CHK("irq take", 1'b1, irq)
            wr(OFS_FLAG_BASE + 8'(v / 16), 16'h0000);
            en(v, 1'b0);
            wr(OFS_EVT_CLEAR, 16'h0001);
        end
        $display("test random done");
        end_of_test();
    end
endmodule
